// >>> include/kgr_pkg.sv
// Purpose: shared constants and types for the host status / fast gate block
// Assumes: 50 MHz controller clock, host strobes arrive as pins
// Notes:   register images and timing counts live here only
package kgr_pkg;
  localparam logic [7:0] ADDR_DATA    = 8'h60;
  localparam logic [7:0] ADDR_CMD     = 8'h64;
  localparam logic [7:0] ADDR_ALT     = 8'h92;
  localparam int         ADDR_CD_BIT  = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_USER  = 8'hf4;
  localparam logic [7:0] ALT_RESET    = 8'h24;
  localparam logic [7:0] ALT_FIXED    = 8'hfc;
  localparam int         ALT_GATE_BIT = 1;
  localparam int         ALT_RST_BIT  = 0;
  localparam logic [7:0] CMD_GATE     = 8'hd1;
  localparam logic [7:0] CMD_RESET    = 8'hfe;
  localparam logic [7:0] CMD_NULL     = 8'hff;
  localparam int         DATA_GATE    = 1;
  localparam int         DATA_RST     = 0;
  localparam int         CLK_NS       = 20;
  localparam int         RST_MIN_CYC  = 24;
  localparam int         DELAY_NS     = 14000;
  localparam int         WIDTH_NS     = 6000;
  localparam int         DELAY_CYC    = (DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int         WIDTH_CYC    = (WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int         CNT_W        = 10;
  localparam int         WR_IDX       = 0;
  localparam int         RD_IDX       = 1;

  typedef struct packed {
    logic [4:0] reserved;
    logic       port_en;
    logic       gate_hw;
    logic       reset_hw;
  } kgr_cfg_t;

  typedef struct packed {
    logic [3:0] user_hi;
    logic       cmd_data;
    logic       user_lo;
    logic       input_buffer_full;
    logic       output_buffer_full;
  } kgr_status_t;

  typedef enum logic {
    SPD_IDLE,
    SPD_WAIT_DATA
  } kgr_speed_t;
endpackage : kgr_pkg

// >>> rtl/kgr_pulse_gen.sv
// Purpose: delayed active-low reset pulse after a single fire request
// Assumes: i_fire is one cycle, same clock domain
// Notes:   fires while busy are dropped
`timescale 1ns/1ps
module kgr_pulse_gen (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  input  wire logic i_fire,
  output logic      o_pulse_n,
  output logic      o_busy
);
  localparam logic [kgr_pkg::CNT_W-1:0] DLY =
    kgr_pkg::CNT_W'(kgr_pkg::DELAY_CYC);
  localparam logic [kgr_pkg::CNT_W-1:0] WID =
    kgr_pkg::CNT_W'(kgr_pkg::WIDTH_CYC);

  logic [kgr_pkg::CNT_W-1:0] cnt;
  logic                      low_phase;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt       <= '0;
      low_phase <= 1'b0;
      o_busy    <= 1'b0;
      o_pulse_n <= 1'b1;
    end else if (i_ce) begin
      if (!o_busy) begin
        if (i_fire) begin
          o_busy <= 1'b1;
          cnt    <= DLY - 1'b1;
        end
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end else if (!low_phase) begin
        low_phase <= 1'b1;
        o_pulse_n <= 1'b0;
        cnt       <= WID - 1'b1;
      end else begin
        low_phase <= 1'b0;
        o_pulse_n <= 1'b1;
        o_busy    <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper counters: cycles since fire, cycles low
  logic [kgr_pkg::CNT_W-1:0] since_fire;
  logic [kgr_pkg::CNT_W-1:0] low_len;
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !o_busy) begin
      since_fire <= '0;
      low_len    <= '0;
    end else if (i_ce) begin
      since_fire <= since_fire + 1'b1;
      if (!o_pulse_n) begin
        low_len <= low_len + 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  pulse_delay_a: assert property (
    i_ce && $fell(o_pulse_n) |-> since_fire == DLY)
    else $error("reset pulse started at the wrong delay");
  pulse_width_a: assert property (
    i_ce && $rose(o_pulse_n) |-> low_len == WID)
    else $error("reset pulse has the wrong width");
endmodule : kgr_pulse_gen

// >>> rtl/kgr_host_gate.sv
// Purpose: host status byte, input/output data, alternate port, fast gate
// Assumes: host address and data stable while the strobe is low
// Notes:   host strobes pass a three-stage synchroniser before use
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - status has output full D0, input full D1, command flag D3, rest user
// - host only reads status; controller reads and writes it
// - host input write copies address bit 2 into the command flag
// - host input write sets input full and the controller interrupt
// - controller read of input data clears input full and interrupt
// - controller write of output data sets output full
// - host read of output data clears output full
// - reset clears status to zero
// - alternate port answers the host only while port enable is set
// - alternate port is 8 bits at 92h, default 24h
// - alternate port bits 7:6,4,3 read 0, bits 5,2 read 1
// - alternate bit 1 drives alternate gate level; reset makes it low
// - writing 1 to bit 0 gives low pulse, 14us delay, 6us wide
// - no new pulse until bit 0 returns to 0; reset clears it
// - config bit 0 selects firmware or hardware reset for command FE
// - enabled alternate pulse ANDed with command pulse, polarity applied
// - gate pin is OR of controller gate and alternate gate bit while port enable is set
// - hardware D1 then data copies bits 1 and 0, input full untouched
// - other command after D1 sets input full and returns to idle
// - config bit 2 port enable, bit 1 gate speed-up, bit 0 reset one
module kgr_host_gate (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_ce,
  input  wire logic             i_host_wr_n,
  input  wire logic             i_host_rd_n,
  input  wire logic [7:0]       i_host_addr,
  input  wire logic [7:0]       i_host_wdata,
  output logic      [7:0]       o_host_rdata,
  output logic                  o_host_rdata_oe,
  input  wire logic             i_mc_rd_input,
  input  wire logic             i_mc_wr_output,
  input  wire logic             i_mc_wr_status,
  input  wire logic [7:0]       i_mc_wdata,
  input  wire logic             i_in_full_irq_en,
  output logic      [7:0]       o_micro_data_buffer,
  output kgr_pkg::kgr_status_t  o_status,
  output logic                  o_input_full_interrupt_n,
  input  wire kgr_pkg::kgr_cfg_t i_fast_gate_reset_config,
  input  wire logic             i_gp_polarity,
  input  wire logic             i_controller_address20_gate,
  input  wire logic             i_controller_cpu_reset_n,
  output logic                  o_alternate_gate_bit,
  output logic                  o_alternate_cpu_reset_n,
  output logic                  o_address20_gate_pin,
  output logic                  o_keyboard_cpu_reset_pin
);
  kgr_pkg::kgr_cfg_t cfg;
  assign cfg = i_fast_gate_reset_config;

  ////////////////////////////////////////////////////////////////////////////
  // strobe synchronisers: a change counts once stages 2 and 3 agree
  logic [1:0] strb_pin;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  logic [1:0] strb_lvl;
  logic [1:0] strb_fall;
  logic [1:0] strb_rise;
  assign strb_pin = {i_host_rd_n, i_host_wr_n};

  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        sync1[g]    <= 1'b1;
        sync2[g]    <= 1'b1;
        sync3[g]    <= 1'b1;
        strb_lvl[g] <= 1'b1;
      end else if (i_ce) begin
        sync1[g] <= strb_pin[g];
        sync2[g] <= sync1[g];
        sync3[g] <= sync2[g];
        if (sync2[g] == sync3[g]) begin
          strb_lvl[g] <= sync3[g];
        end
      end
    end
    assign strb_fall[g] = i_ce && sync2[g] == sync3[g] &&
                          strb_lvl[g] && !sync3[g];
    assign strb_rise[g] = i_ce && sync2[g] == sync3[g] &&
                          !strb_lvl[g] && sync3[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // host request decode
  logic host_wr;
  logic wr_data;
  logic wr_cmd;
  logic wr_alt;
  logic alt_live;
  logic [7:0] rd_addr;
  logic rd_data_end;
  kgr_pkg::kgr_speed_t state;
  logic swallow;
  logic to_fw;

  assign host_wr  = strb_fall[kgr_pkg::WR_IDX];
  assign alt_live = cfg.port_en;
  assign wr_data  = host_wr && i_host_addr == kgr_pkg::ADDR_DATA;
  assign wr_cmd   = host_wr && i_host_addr == kgr_pkg::ADDR_CMD;
  assign wr_alt   = host_wr && i_host_addr == kgr_pkg::ADDR_ALT && alt_live;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rd_addr <= 8'h00;
    end else if (strb_fall[kgr_pkg::RD_IDX]) begin
      rd_addr <= i_host_addr;
    end
  end
  // clear at the end of the read so the host sees a stable byte
  assign rd_data_end = strb_rise[kgr_pkg::RD_IDX] &&
                       rd_addr == kgr_pkg::ADDR_DATA;

  ////////////////////////////////////////////////////////////////////////////
  // hardware speed-up: D1 plus data, FE, null command FF
  logic gate_latch;
  logic reset_latch;
  logic fe_fire;

  always_comb begin
    swallow = 1'b0;
    if (cfg.gate_hw && state == kgr_pkg::SPD_WAIT_DATA) begin
      swallow = wr_data || (wr_cmd && i_host_wdata == kgr_pkg::CMD_GATE);
    end else if (wr_cmd) begin
      swallow = (cfg.gate_hw && (i_host_wdata == kgr_pkg::CMD_GATE ||
                                 i_host_wdata == kgr_pkg::CMD_NULL)) ||
                (cfg.reset_hw && i_host_wdata == kgr_pkg::CMD_RESET);
    end
  end
  assign to_fw   = (wr_data || wr_cmd) && !swallow;
  assign fe_fire = wr_cmd && swallow && i_host_wdata == kgr_pkg::CMD_RESET;

  always_ff @(posedge i_clk) begin
    if (!i_resetn || (i_ce && !cfg.gate_hw)) begin
      state <= kgr_pkg::SPD_IDLE;
    end else if (i_ce) begin
      case (state)
        kgr_pkg::SPD_IDLE: begin
          if (wr_cmd && i_host_wdata == kgr_pkg::CMD_GATE) begin
            state <= kgr_pkg::SPD_WAIT_DATA;
          end
        end
        kgr_pkg::SPD_WAIT_DATA: begin
          if (wr_data) begin
            state <= kgr_pkg::SPD_IDLE;
          end else if (wr_cmd && i_host_wdata != kgr_pkg::CMD_GATE) begin
            state <= kgr_pkg::SPD_IDLE;
          end
        end
        default: state <= kgr_pkg::SPD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      gate_latch  <= 1'b0;
      reset_latch <= 1'b1;
    end else if (i_ce && state == kgr_pkg::SPD_WAIT_DATA && wr_data) begin
      gate_latch  <= i_host_wdata[kgr_pkg::DATA_GATE];
      reset_latch <= i_host_wdata[kgr_pkg::DATA_RST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status byte and data buffers; set wins over clear
  logic [7:0] out_data;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_status <= kgr_pkg::STATUS_RESET;
    end else if (i_ce) begin
      if (i_mc_wr_status) begin
        o_status <= (i_mc_wdata & kgr_pkg::STATUS_USER) |
                    (o_status & ~kgr_pkg::STATUS_USER);
      end
      if (rd_data_end) begin
        o_status.output_buffer_full <= 1'b0;
      end
      if (i_mc_wr_output) begin
        o_status.output_buffer_full <= 1'b1;
      end
      if (i_mc_rd_input) begin
        o_status.input_buffer_full <= 1'b0;
      end
      if (to_fw) begin
        o_status.input_buffer_full <= 1'b1;
        o_status.cmd_data <= i_host_addr[kgr_pkg::ADDR_CD_BIT];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_micro_data_buffer <= 8'h00;
      out_data            <= 8'h00;
    end else if (i_ce) begin
      if (to_fw) begin
        o_micro_data_buffer <= i_host_wdata;
      end
      if (i_mc_wr_output) begin
        out_data <= i_mc_wdata;
      end
    end
  end

  // interrupt withdrawn in the same cycle the flag drops
  assign o_input_full_interrupt_n =
    !(o_status.input_buffer_full && i_in_full_irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // alternate port at 92h
  logic       alt_rst_bit;
  logic [7:0] alt_view;
  logic       alt_fire;
  logic       alt_pulse_n;
  logic       fe_pulse_n;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_alternate_gate_bit <= kgr_pkg::ALT_RESET[kgr_pkg::ALT_GATE_BIT];
      alt_rst_bit          <= kgr_pkg::ALT_RESET[kgr_pkg::ALT_RST_BIT];
    end else if (i_ce && wr_alt) begin
      o_alternate_gate_bit <= i_host_wdata[kgr_pkg::ALT_GATE_BIT];
      alt_rst_bit <= i_host_wdata[kgr_pkg::ALT_RST_BIT];
    end
  end

  assign alt_view = (kgr_pkg::ALT_RESET & kgr_pkg::ALT_FIXED) |
                    {6'h00, o_alternate_gate_bit, alt_rst_bit};
  // only a 0 to 1 edge of the bit arms a pulse
  assign alt_fire = wr_alt && i_host_wdata[kgr_pkg::ALT_RST_BIT] &&
                    !alt_rst_bit;

  kgr_pulse_gen u_alt_pulse (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_ce      (i_ce),
    .i_fire    (alt_fire),
    .o_pulse_n (alt_pulse_n),
    .o_busy    ()
  );

  kgr_pulse_gen u_fe_pulse (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_ce      (i_ce),
    .i_fire    (fe_fire),
    .o_pulse_n (fe_pulse_n),
    .o_busy    ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // output merging, registered so pins never glitch
  logic ctl_gate;
  logic ctl_reset_n;
  logic merged_reset_n;
  logic merged_gate;

  assign ctl_gate    = cfg.gate_hw ? gate_latch : i_controller_address20_gate;
  assign ctl_reset_n = cfg.reset_hw ? (fe_pulse_n && reset_latch)
                                    : i_controller_cpu_reset_n;
  assign merged_reset_n = ctl_reset_n &&
                          (!alt_live || alt_pulse_n);
  assign merged_gate = ctl_gate ||
                       (alt_live && o_alternate_gate_bit);

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_alternate_cpu_reset_n  <= 1'b1;
      o_keyboard_cpu_reset_pin <= 1'b1;
      o_address20_gate_pin     <= 1'b0;
    end else if (i_ce) begin
      o_alternate_cpu_reset_n  <= alt_pulse_n;
      o_keyboard_cpu_reset_pin <= merged_reset_n ^ i_gp_polarity;
      o_address20_gate_pin     <= merged_gate ^ i_gp_polarity;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host read path
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_host_rdata <= 8'h00;
    end else if (i_ce) begin
      case (i_host_addr)
        kgr_pkg::ADDR_DATA: o_host_rdata <= out_data;
        kgr_pkg::ADDR_CMD:  o_host_rdata <= o_status;
        kgr_pkg::ADDR_ALT:  o_host_rdata <= alt_view;
        default:            o_host_rdata <= 8'h00;
      endcase
    end
  end

  assign o_host_rdata_oe = !strb_lvl[kgr_pkg::RD_IDX] &&
    (rd_addr == kgr_pkg::ADDR_DATA || rd_addr == kgr_pkg::ADDR_CMD ||
     (rd_addr == kgr_pkg::ADDR_ALT && alt_live));

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_gate_cmd;
    wr_cmd && cfg.gate_hw && i_host_wdata == kgr_pkg::CMD_GATE;
  endsequence
  sequence s_bad_cmd;
    state == kgr_pkg::SPD_WAIT_DATA && cfg.gate_hw && wr_cmd &&
    i_host_wdata != kgr_pkg::CMD_GATE;
  endsequence
  sequence s_gate_data;
    state == kgr_pkg::SPD_WAIT_DATA && cfg.gate_hw && wr_data;
  endsequence

  in_full_set_a: assert property (
    to_fw |=> o_status.input_buffer_full && !o_input_full_interrupt_n ==
      $past(i_in_full_irq_en))
    else $error("input full not raised by host write");
  in_full_clr_a: assert property (
    i_ce && i_mc_rd_input && !to_fw |=> !o_status.input_buffer_full)
    else $error("input full not cleared by controller read");
  out_full_set_a: assert property (
    i_ce && i_mc_wr_output |=> o_status.output_buffer_full)
    else $error("output full not set by controller write");
  out_full_clr_a: assert property (
    rd_data_end && !i_mc_wr_output |=> !o_status.output_buffer_full)
    else $error("output full not cleared by host read");
  cd_follow_a: assert property (
    to_fw |=> o_status.cmd_data == $past(i_host_addr[kgr_pkg::ADDR_CD_BIT]))
    else $error("command flag does not follow address bit 2");
  user_keep_a: assert property (
    to_fw && !i_mc_wr_status && !i_mc_wr_output && !rd_data_end |=>
      $stable(o_status.user_hi) && $stable(o_status.user_lo) &&
      $stable(o_status.output_buffer_full))
    else $error("host write disturbed other status bits");
  status_reset_a: assert property (
    @(posedge i_clk) disable iff (1'b0) !i_resetn |=> o_status == 8'h00)
    else $error("status not cleared by reset");
  alt_fixed_a: assert property (
    i_ce && i_host_addr == kgr_pkg::ADDR_ALT |=>
      (o_host_rdata & kgr_pkg::ALT_FIXED) == 8'h24)
    else $error("alternate port fixed bits wrong");
  alt_gated_a: assert property (
    host_wr && i_host_addr == kgr_pkg::ADDR_ALT && !cfg.port_en |=>
      $stable(o_alternate_gate_bit) && $stable(alt_rst_bit))
    else $error("alternate port answered while disabled");
  gate_or_a: assert property (
    i_ce |=> o_address20_gate_pin == ($past(merged_gate) ^
      $past(i_gp_polarity)) && (!$past(alt_live && o_alternate_gate_bit)
      || o_address20_gate_pin != $past(i_gp_polarity)))
    else $error("gate pin is not the OR of its sources");
  d1_wait_a: assert property (
    s_gate_cmd |=> state == kgr_pkg::SPD_WAIT_DATA)
    else $error("D1 did not arm the data wait");
  d1_data_a: assert property (
    s_gate_data and !i_mc_rd_input |=> state == kgr_pkg::SPD_IDLE &&
      gate_latch == $past(i_host_wdata[kgr_pkg::DATA_GATE]) &&
      reset_latch == $past(i_host_wdata[kgr_pkg::DATA_RST]) &&
      o_status.input_buffer_full == $past(o_status.input_buffer_full))
    else $error("D1 data not latched transparently");
  d1_bad_a: assert property (
    s_bad_cmd |=> state == kgr_pkg::SPD_IDLE && o_status.input_buffer_full)
    else $error("stray command after D1 not flagged");
  no_refire_a: assert property (
    alt_rst_bit && wr_alt |-> !alt_fire)
    else $error("second pulse without clearing bit 0");
endmodule : kgr_host_gate

// >>> tb/kgr_bus_model.sv
// Purpose: host bus and controller stand-in for the gate block
// Assumes: drives on the falling clock edge only
// Notes:   idle address and data carry the inverse of their last value
`timescale 1ns/1ps
module kgr_bus_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_oe,
  output logic            o_wr_n,
  output logic            o_rd_n,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata,
  output logic            o_mc_rd,
  output logic            o_mc_wr,
  output logic            o_mc_st,
  output logic [7:0]      o_mc_wdata
);
  initial begin
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    {o_mc_rd, o_mc_wr, o_mc_st} = 3'b000;
    o_mc_wdata = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic idle(input int n);
    repeat (n) @(negedge i_clk);
  endtask : idle

  // strobe held six cycles each way so the synchroniser sees both levels
  task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
    o_addr = a;
    o_wdata = d;
    o_wr_n = 1'b0;
    idle(6);
    o_wr_n = 1'b1;
    idle(5);
    o_addr = ~a;
    o_wdata = ~d;
    idle(1);
  endtask : host_wr

  task automatic host_rd(input logic [7:0] a, output logic [7:0] d,
                         output logic e);
    o_addr = a;
    o_rd_n = 1'b0;
    idle(5);
    e = i_oe;
    d = i_rdata;
    o_rd_n = 1'b1;
    idle(5);
    o_addr = ~a;
    idle(1);
  endtask : host_rd

  // s is {read input, write output, write status}
  task automatic mc(input logic [2:0] s, input logic [7:0] d);
    o_mc_wdata = d;
    {o_mc_rd, o_mc_wr, o_mc_st} = s;
    idle(1);
    {o_mc_rd, o_mc_wr, o_mc_st} = 3'b000;
    o_mc_wdata = ~d;
    idle(2);
  endtask : mc
endmodule : kgr_bus_model

// >>> tb/test_kgr_host_gate.sv
// Purpose: self-checking bench for the host status and fast gate block
// Assumes: 50 MHz clock, bus model drives on the falling edge
// Notes:   pulse timing is judged as minimum figures only
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); \
  end \
end
module test_kgr_host_gate;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic              wr_n, rd_n, oe, mc_rd, mc_wr, mc_st;
  logic [7:0]        addr, wdata, rdata, mc_wdata, micro_buf;
  logic              irq_en = 1'b1;
  logic              pol = 1'b0;
  logic              ctl_gate = 1'b0;
  logic              ctl_rst_n = 1'b1;
  logic              irq_n, alt_gate, alt_rst_n, gate_pin, kbd_pin;
  kgr_pkg::kgr_status_t status;
  kgr_pkg::kgr_cfg_t    cfg = 8'h04;
  int                checked = 0;
  int                miscompares = 0;

  initial forever #10 clk = ~clk;

  kgr_bus_model m (.i_clk(clk), .i_rdata(rdata), .i_oe(oe),
    .o_wr_n(wr_n), .o_rd_n(rd_n), .o_addr(addr), .o_wdata(wdata),
    .o_mc_rd(mc_rd), .o_mc_wr(mc_wr), .o_mc_st(mc_st),
    .o_mc_wdata(mc_wdata));

  kgr_host_gate uut (.i_clk(clk), .i_resetn(resetn), .i_ce(1'b1),
    .i_host_wr_n(wr_n), .i_host_rd_n(rd_n), .i_host_addr(addr),
    .i_host_wdata(wdata), .o_host_rdata(rdata), .o_host_rdata_oe(oe),
    .i_mc_rd_input(mc_rd), .i_mc_wr_output(mc_wr),
    .i_mc_wr_status(mc_st), .i_mc_wdata(mc_wdata),
    .i_in_full_irq_en(irq_en), .o_micro_data_buffer(micro_buf),
    .o_status(status), .o_input_full_interrupt_n(irq_n),
    .i_fast_gate_reset_config(cfg), .i_gp_polarity(pol),
    .i_controller_address20_gate(ctl_gate),
    .i_controller_cpu_reset_n(ctl_rst_n),
    .o_alternate_gate_bit(alt_gate), .o_alternate_cpu_reset_n(alt_rst_n),
    .o_address20_gate_pin(gate_pin), .o_keyboard_cpu_reset_pin(kbd_pin));
  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // bounded watch of the keyboard reset pin, in cycles
  task automatic pulse(input bit want, output int dly, output int wid,
                       output logic a);
    dly = 0;
    wid = 0;
    while (kbd_pin !== 1'b0 && dly < 1200) begin
      @(negedge clk);
      dly++;
    end
    a = alt_rst_n;
    while (kbd_pin === 1'b0 && wid < 1200) begin
      @(negedge clk);
      wid++;
    end
    if ((want && dly == 1200) || wid == 1200) begin
      miscompares++;
      $display("ERROR %0t: reset pulse missing or stuck", $time);
      report_and_stop();
    end
  endtask : pulse

  task automatic t_reset();
    logic [7:0] d;
    logic       e;
    resetn = 1'b0;
    repeat (24) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(status, kgr_pkg::STATUS_RESET)
    `CHK({alt_gate, alt_rst_n, gate_pin}, 3'b010)
    m.host_rd(kgr_pkg::ADDR_ALT, d, e);
    `CHK({e, d}, {1'b1, kgr_pkg::ALT_RESET})
  endtask : t_reset

  task automatic t_host();
    logic [7:0] d;
    logic       e;
    m.mc(3'b001, 8'hff);
    `CHK(status, 8'hf4)
    m.host_wr(kgr_pkg::ADDR_CMD, 8'h5a);
    `CHK({status, micro_buf, irq_n}, {8'hfe, 8'h5a, 1'b0})
    m.host_rd(kgr_pkg::ADDR_CMD, d, e);
    `CHK(d, 8'hfe)
    m.mc(3'b100, 8'h00);
    `CHK({status, irq_n}, {8'hfc, 1'b1})
    m.host_wr(kgr_pkg::ADDR_DATA, 8'h3c);
    `CHK(status, 8'hf6)
    m.mc(3'b010, 8'ha5);
    `CHK(status, 8'hf7)
    m.host_rd(kgr_pkg::ADDR_DATA, d, e);
    `CHK({d, status}, {8'ha5, 8'hf6})
    m.mc(3'b100, 8'h00);
  endtask : t_host

  task automatic t_port();
    logic [7:0] d;
    logic       e;
    cfg = 8'h00;
    m.host_wr(kgr_pkg::ADDR_ALT, 8'h02);
    m.host_rd(kgr_pkg::ADDR_ALT, d, e);
    `CHK({e, alt_gate}, 2'b00)
    cfg = 8'h04;
    m.host_wr(kgr_pkg::ADDR_ALT, 8'h02);
    m.host_rd(kgr_pkg::ADDR_ALT, d, e);
    `CHK({e, d, alt_gate, gate_pin}, {9'h126, 2'b11})
    m.host_wr(kgr_pkg::ADDR_ALT, 8'hf8);
    ctl_gate = 1'b1;
    m.host_rd(kgr_pkg::ADDR_ALT, d, e);
    `CHK({d, alt_gate, gate_pin}, {8'h24, 2'b01})
    pol = 1'b1;
    repeat (3) @(negedge clk);
    `CHK({gate_pin, kbd_pin}, 2'b00)
    pol = 1'b0;
    ctl_gate = 1'b0;
    ctl_rst_n = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(kbd_pin, 1'b0)
    ctl_rst_n = 1'b1;
  endtask : t_port

  task automatic t_alt();
    int   dly, wid;
    logic a;
    m.host_wr(kgr_pkg::ADDR_ALT, 8'h01);
    pulse(1'b1, dly, wid, a);
    `CHK({dly >= 680, wid >= 300, a}, 3'b110)
    m.host_wr(kgr_pkg::ADDR_ALT, 8'h01);
    pulse(1'b0, dly, wid, a);
    `CHK(dly, 1200)
    m.host_wr(kgr_pkg::ADDR_ALT, 8'h00);
    m.host_wr(kgr_pkg::ADDR_ALT, 8'h01);
    pulse(1'b1, dly, wid, a);
    `CHK({dly >= 680, wid >= 300}, 2'b11)
  endtask : t_alt

  task automatic t_speed();
    int   dly, wid;
    logic a;
    cfg = 8'h06;
    m.host_wr(kgr_pkg::ADDR_CMD, kgr_pkg::CMD_GATE);
    m.host_wr(kgr_pkg::ADDR_DATA, 8'h03);
    m.host_wr(kgr_pkg::ADDR_CMD, kgr_pkg::CMD_NULL);
    `CHK({status.input_buffer_full, gate_pin}, 2'b01)
    m.host_wr(kgr_pkg::ADDR_CMD, kgr_pkg::CMD_GATE);
    m.host_wr(kgr_pkg::ADDR_CMD, 8'h33);
    `CHK({status.input_buffer_full, micro_buf}, 9'h133)
    m.mc(3'b100, 8'h00);
    m.host_wr(kgr_pkg::ADDR_CMD, kgr_pkg::CMD_GATE);
    m.host_wr(kgr_pkg::ADDR_DATA, 8'h01);
    `CHK({status.input_buffer_full, gate_pin}, 2'b00)
    cfg = 8'h00;
    m.host_wr(kgr_pkg::ADDR_CMD, kgr_pkg::CMD_RESET);
    `CHK({status.input_buffer_full, micro_buf}, 9'h1fe)
    m.mc(3'b100, 8'h00);
    cfg = 8'h01;
    m.host_wr(kgr_pkg::ADDR_CMD, kgr_pkg::CMD_RESET);
    pulse(1'b1, dly, wid, a);
    `CHK({status.input_buffer_full, dly >= 680, wid >= 300}, 3'b011)
  endtask : t_speed

  initial begin
    t_reset();
    t_host();
    t_port();
    t_alt();
    t_speed();
    report_and_stop();
  end
endmodule : test_kgr_host_gate
